//--- rtl/pwm_trig_pkg.sv
// Package for the alternate dead-time and trigger postscaler block.
// Assumes a 16-bit register port and a 100 MHz PWM clock.
package pwm_trig_pkg;
   localparam int REG_W = 16;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ALT_DT_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] TRIG_CTRL_ADDR = 4'h1;
   localparam logic [ADDR_W-1:0] UPD_CTRL_ADDR = 4'h2;
   localparam int DT_W = 14;
   localparam int DIV_W = 4;
   localparam int DIV_LSB = 12;
   localparam int STRT_W = 6;
   localparam int STRT_LSB = 0;
   localparam int IUE_BIT = 0;
   localparam int STATE_LSB = 8;
   localparam int STATE_W = 2;
   localparam logic [DT_W-1:0] DT_RST = 14'h0000;
   localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
   localparam logic [STRT_W-1:0] STRT_RST = 6'h00;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10
   } trig_state_t;

   // Register port request as seen by the block
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Events from the time base
   typedef struct packed {
      logic enable;
      logic cycle_start;
      logic trig_event;
   } pwm_evt_t;
endpackage

//--- rtl/trig_postscaler.sv
// Trigger start delay and postscaler for one PWM generator.
// Assumes one-cycle event pulses on the same clock as the block.
`timescale 1ns/100ps
`default_nettype none
module trig_postscaler
   import pwm_trig_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire pwm_evt_t evt,
   input wire logic [DIV_W-1:0] trigger_output_divider,
   input wire logic [STRT_W-1:0] trigger_start_delay,
   output logic trig_out,
   output logic [1:0] trig_state
);
   typedef struct packed {
      trig_state_t st;
      logic [STRT_W-1:0] wait_cnt;
      logic [DIV_W-1:0] div_cnt;
      logic trig;
   } ps_state_t;

   ps_state_t s_reg;
   ps_state_t s_next;

   // Start delay counts PWM cycles, then postscaler passes 1 of trigger_output_divider+1 events
   always_comb begin
      s_next = s_reg;
      s_next.trig = 1'b0;
      case (s_reg.st)
         ST_OFF: begin
            s_next.div_cnt = DIV_RST;
            s_next.wait_cnt = STRT_RST;
            if (evt.enable) begin
               s_next.st = (trigger_start_delay == STRT_RST) ?
                           ST_RUN : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (evt.cycle_start) begin
               s_next.wait_cnt = s_reg.wait_cnt + 6'h01;
               if (s_next.wait_cnt >= trigger_start_delay) begin
                  s_next.st = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (evt.trig_event) begin
               // Divider compare uses >= so a lowered value cannot stall
               if (s_reg.div_cnt >= trigger_output_divider) begin
                  s_next.div_cnt = DIV_RST;
                  s_next.trig = 1'b1;
               end else begin
                  s_next.div_cnt = s_reg.div_cnt + 4'h1;
               end
            end
         end
         default: s_next.st = ST_OFF;
      endcase
      if (!evt.enable) begin
         s_next.st = ST_OFF;
         s_next.trig = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{st: ST_OFF, wait_cnt: STRT_RST, div_cnt: DIV_RST,
                    trig: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign trig_out = s_reg.trig;
   assign trig_state = s_reg.st;
endmodule
`default_nettype wire

//--- rtl/pwm_altdt_trig.sv
// Alternate dead-time register and ADC trigger postscaler of a PWM generator.
// Holds the three software registers and the postscaler instance.
// Assumes a simple strobe register port and time-base pulses on clk.
// Event inputs come from logic on clk and need no synchroniser.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pwm_altdt_trig
   import pwm_trig_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [REG_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [REG_W-1:0] rdata,
   // Time-base events
   input wire logic pwm_enable,
   input wire logic cycle_start,
   input wire logic trig_event,
   // Dead-time unit and ADC trigger
   output logic [DT_W-1:0] alternate_dead_time_value,
   output logic adc_trigger
);
   ////////////////////////////////////////////////////////////////////////
   // Reset release
   // Reset enters at once but leaves on a clock edge, so no register
   // sees the release in the middle of a cycle
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   // Only the second flip-flop feeds the rest of the block
   assign rst_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // Register state
   // dt_buf is what software wrote, dt_act what the dead-time unit uses
   typedef struct packed {
      logic [DT_W-1:0] dt_buf;
      logic [DT_W-1:0] dt_act;
      logic [DIV_W-1:0] div;
      logic [STRT_W-1:0] strt;
      logic immediate_update_select;
      logic [REG_W-1:0] rdata;
   } regs_t;

   regs_t r_reg;
   regs_t r_next;
   reg_req_t req;
   pwm_evt_t evt;
   // Postscaler state, shown in the update control word
   logic [1:0] trig_state;

   // Ports bundled into the package carriers
   assign req = '{addr: addr,
                  wdata: wdata,
                  wr: wr,
                  rd: rd};
   assign evt = '{enable: pwm_enable,
                  cycle_start: cycle_start,
                  trig_event: trig_event};

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   // One decode serves both paths, so a write and a read of the same
   // address always select the same register; unmapped ones select none
   logic sel_alt_dt;
   logic sel_trig_ctrl;
   logic sel_upd_ctrl;
   logic wr_alt_dt;
   logic wr_trig_ctrl;
   logic wr_upd_ctrl;
   logic rd_alt_dt;
   logic rd_trig_ctrl;
   logic rd_upd_ctrl;

   // Register selects
   assign sel_alt_dt = (req.addr == ALT_DT_ADDR);
   assign sel_trig_ctrl = (req.addr == TRIG_CTRL_ADDR);
   assign sel_upd_ctrl = (req.addr == UPD_CTRL_ADDR);

   // Qualified strobes; the master never raises both in one cycle
   assign wr_alt_dt = req.wr && sel_alt_dt;
   assign wr_trig_ctrl = req.wr && sel_trig_ctrl;
   assign wr_upd_ctrl = req.wr && sel_upd_ctrl;
   assign rd_alt_dt = req.rd && sel_alt_dt;
   assign rd_trig_ctrl = req.rd && sel_trig_ctrl;
   assign rd_upd_ctrl = req.rd && sel_upd_ctrl;

   ////////////////////////////////////////////////////////////////////////
   // Write fields
   // Only implemented bits are sliced out, so the upper dead-time bits and
   // the control gap bits are dropped here and never reach the state
   logic [DT_W-1:0] wf_dead_time;
   logic [DIV_W-1:0] wf_divider;
   logic [STRT_W-1:0] wf_start;
   logic wf_immediate;

   // Field slices of the write word
   assign wf_dead_time = req.wdata[DT_W-1:0];
   assign wf_divider = req.wdata[DIV_LSB +: DIV_W];
   assign wf_start = req.wdata[STRT_LSB +: STRT_W];
   assign wf_immediate = req.wdata[IUE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Read images
   // Each image is the whole word as software sees it; bits that are not
   // implemented are tied to zero here, not left to the read mux
   logic [REG_W-1:0] img_alt_dt;
   logic [REG_W-1:0] img_trig_ctrl;
   logic [REG_W-1:0] img_upd_ctrl;
   logic [REG_W-1:0] rd_word;

   // Dead time: the buffered copy, so a read returns the last write
   // even while a synchronised update is still pending
   assign img_alt_dt = {{(REG_W-DT_W){1'b0}}, r_reg.dt_buf};

   // Trigger control: divider on top, start delay at the bottom
   assign img_trig_ctrl = {r_reg.div, {(DIV_LSB-STRT_W){1'b0}},
                           r_reg.strt};

   // Update control: immediate flag and the postscaler state
   assign img_upd_ctrl = {{(REG_W-STATE_LSB-STATE_W){1'b0}}, trig_state,
                          {(STATE_LSB-IUE_BIT-1){1'b0}}, r_reg.immediate_update_select};

   // Read mux, one bit at a time; selects are one-hot, so idle cycles
   // and unmapped addresses give an all-zero word
   for (genvar b = 0; b < REG_W; b++) begin : g_rd_bit
      assign rd_word[b] = (rd_alt_dt && img_alt_dt[b]) ||
                          (rd_trig_ctrl && img_trig_ctrl[b]) ||
                          (rd_upd_ctrl && img_upd_ctrl[b]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   // Writes, shadow transfer and read capture all land here
   always_comb begin
      r_next = r_reg;
      // Buffered value moves to active copy on each PWM cycle start while immediate update is off
      if (!r_reg.immediate_update_select && evt.cycle_start) begin
         r_next.dt_act = r_reg.dt_buf;
      end
      // With immediate update off, a write beside a cycle start lands in the buffer and waits for
      // the next cycle start; the older buffer goes live this time
      if (wr_alt_dt) begin
         r_next.dt_buf = wf_dead_time;
         if (r_reg.immediate_update_select) begin
            r_next.dt_act = wf_dead_time;
         end
      end
      // Control fields take the write as it stands
      if (wr_trig_ctrl) begin
         r_next.div = wf_divider;
         r_next.strt = wf_start;
      end
      // Immediate flag sets how later writes land and turns off the cycle-start transfer
      if (wr_upd_ctrl) begin
         r_next.immediate_update_select = wf_immediate;
      end
      // Read data stands for one cycle only, zero otherwise
      r_next.rdata = rd_word;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   // All implemented bits clear on reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '{dt_buf: DT_RST,
                    dt_act: DT_RST,
                    div: DIV_RST,
                    strt: STRT_RST,
                    immediate_update_select: 1'b0,
                    rdata: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from flip-flops
   assign rdata = r_reg.rdata;
   assign alternate_dead_time_value = r_reg.dt_act;

   ////////////////////////////////////////////////////////////////////////
   // Trigger path
   // The postscaler reads the live control fields, so a divider or start
   // change takes hold at the next event; software should set them while
   // the generator is disabled
   logic [DIV_W-1:0] ps_divider;
   logic [STRT_W-1:0] ps_start;

   // Control fields feed the postscaler straight from the flip-flops
   assign ps_divider = r_reg.div;
   assign ps_start = r_reg.strt;

   trig_postscaler u_ps (
      .clk(clk),
      .rst_n(rst_n),
      .evt(evt),
      .trigger_output_divider(ps_divider),
      .trigger_start_delay(ps_start),
      .trig_out(adc_trigger),
      .trig_state(trig_state)
   );
endmodule
`default_nettype wire

//--- verif/adc_trigger_sink.sv
// ADC stand-in that counts conversion triggers.
// Assumes one-cycle trigger pulses on clk.
`timescale 1ns/100ps
`default_nettype none
module adc_trigger_sink (
   input wire logic clk,
   input wire logic rstn,
   input wire logic adc_trigger,
   output logic [15:0] conv_count
);
   // Only the number of conversions started matters to the bench
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) conv_count <= 16'h0000;
      else if (adc_trigger) conv_count <= conv_count + 16'h0001;
   end
endmodule
`default_nettype wire

//--- verif/altdt_trig_monitor.sv
// Port checker for the dead-time and trigger block.
// Assumes it is bound to pwm_altdt_trig.
`timescale 1ns/100ps
`default_nettype none
module altdt_trig_monitor
   import pwm_trig_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [REG_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [REG_W-1:0] rdata,
   input wire logic pwm_enable,
   input wire logic trig_event,
   input wire logic cycle_start,
   input wire logic [DT_W-1:0] alternate_dead_time_value,
   input wire logic adc_trigger
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Write then read of the dead time, back to back
   sequence dt_wr_rd;
      wr && addr == ALT_DT_ADDR ##1 rd && !wr && addr == ALT_DT_ADDR;
   endsequence
   a_dt_read_back: assert property (dt_wr_rd |=>
      rdata[13:0] == $past(wdata[13:0], 2)) else $error("dt readback");
   a_dt_upper_zero: assert property (rd && addr == ALT_DT_ADDR |=>
      rdata[15:14] == 2'b00) else $error("dt upper bits");
   a_trig_event_cause: assert property (adc_trigger |->
      $past(trig_event)) else $error("trigger without event");
   a_idle_no_trig: assert property (!pwm_enable [*2] |->
      !adc_trigger) else $error("trigger while disabled");
   // Active value moves only after a write or a cycle start
   a_dt_change_cause: assert property (
      $changed(alternate_dead_time_value) |-> $past(wr) || $past(cycle_start))
      else $error("dead time changed without cause");
   a_ctrl_gap_zero: assert property (rd && addr == TRIG_CTRL_ADDR |=>
      rdata[11:6] == 6'h00) else $error("control gap bits");
endmodule
bind pwm_altdt_trig altdt_trig_monitor mon (.clk(clk), .rstn(rstn),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .pwm_enable(pwm_enable), .trig_event(trig_event),
   .cycle_start(cycle_start), .adc_trigger(adc_trigger),
   .alternate_dead_time_value(alternate_dead_time_value));
`default_nettype wire

//--- verif/pwm_altdt_trig_bench.sv
// Bench for pwm_altdt_trig: register tasks and trigger sequences.
// Assumes the package, checker and ADC stand-in are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pwm_altdt_trig_bench;
   import pwm_trig_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic pwm_enable = 1'b0, cycle_start = 1'b0, trig_event = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [REG_W-1:0] wdata = '0;
   logic [REG_W-1:0] rdata;
   logic [DT_W-1:0] dt;
   logic adc_trigger;
   logic [15:0] convs;
   int num_errors = 0;
   int cmp_count = 0;
   pwm_altdt_trig uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pwm_enable(pwm_enable),
      .cycle_start(cycle_start), .trig_event(trig_event),
      .alternate_dead_time_value(dt), .adc_trigger(adc_trigger));
   adc_trigger_sink adc (.clk(clk), .rstn(rstn), .adc_trigger(adc_trigger),
      .conv_count(convs));
   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Each access is one strobe cycle, so calls may follow back to back
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [15:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
      @(posedge clk);
   endtask
   // Spaced pulses of cycle start (c) or trigger event
   task automatic pulse(input bit c, input int n);
      repeat (n) begin
         cycle_start <= c;
         trig_event <= !c;
         @(posedge clk);
         cycle_start <= 1'b0;
         trig_event <= 1'b0;
         repeat (2) @(posedge clk);
      end
      #1;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Hang guard, far beyond the some 160 cycles the tests need
   initial begin
      #50000;
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(ALT_DT_ADDR, 16'h0000);
      rchk(TRIG_CTRL_ADDR, 16'h0000);
      rchk(4'h3, 16'h0000);
      // A clock edge between two writes keeps wr from being set twice
      wreg(UPD_CTRL_ADDR, 16'h0001);
      @(posedge clk);
      wreg(ALT_DT_ADDR, 16'hffff);
      rchk(ALT_DT_ADDR, 16'h3fff);
      chk({2'b00, dt}, 16'h3fff);
      wreg(UPD_CTRL_ADDR, 16'h0000);
      @(posedge clk);
      wreg(ALT_DT_ADDR, 16'h1234);
      rchk(ALT_DT_ADDR, 16'h1234);
      chk({2'b00, dt}, 16'h3fff);
      pulse(1'b1, 1);
      chk({2'b00, dt}, 16'h1234);
      $display("dead time tests done");
      wreg(TRIG_CTRL_ADDR, 16'hffff);
      rchk(TRIG_CTRL_ADDR, 16'hf03f);
      wreg(TRIG_CTRL_ADDR, 16'h1002);
      pwm_enable <= 1'b1;
      pulse(1'b0, 3);
      chk(convs, 16'h0000);
      rchk(UPD_CTRL_ADDR, 16'h0100);
      pulse(1'b1, 2);
      rchk(UPD_CTRL_ADDR, 16'h0200);
      pulse(1'b0, 6);
      chk(convs, 16'h0003);
      pwm_enable <= 1'b0;
      wreg(TRIG_CTRL_ADDR, 16'he000);
      pwm_enable <= 1'b1;
      repeat (2) @(posedge clk);
      pulse(1'b0, 30);
      chk(convs, 16'h0005);
      $display("trigger tests done");
      complete_run();
   end
endmodule
`default_nettype wire
